// ===== src/hs_pkg.sv
package hs_pkg;

	// ****************************************
	// command codes as decoded from the serial shifter
	// ****************************************
	localparam logic [2:0] CMD_NONE         = 3'h0;
	localparam logic [2:0] CMD_HS_ON        = 3'h1;
	localparam logic [2:0] CMD_HS_OFF       = 3'h2;
	localparam logic [2:0] CMD_READ         = 3'h3;
	localparam logic [2:0] CMD_WRITE        = 3'h4;
	localparam logic [2:0] CMD_HALT         = 3'h5;
	localparam logic [2:0] CMD_RESUME       = 3'h6;
	localparam logic [2:0] CMD_RESUME_UNTIL = 3'h7;

	// ****************************************
	// pulse timing
	// ****************************************
	localparam int  CLK_PERIOD_NS = 20;
	localparam int  PULSE_TIME_NS = 320;
	localparam int  PULSE_CYCLES_I = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] PULSE_CYCLES = PULSE_CYCLES_I[4:0];
	localparam logic [4:0] CNT_ZERO     = 5'h00;
	localparam logic [4:0] CNT_ONE      = 5'h01;

	// ****************************************
	// pending-wait states, gray coded in the order listed
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE       = 3'b000,
		ST_WAIT_BUS   = 3'b001,
		ST_WAIT_HALT  = 3'b011,
		ST_WAIT_RUN   = 3'b010,
		ST_WAIT_STEP  = 3'b110,
		ST_WAIT_LINE  = 3'b111,
		ST_DRIVE      = 3'b101
	} wait_state_type;

endpackage

// ===== src/pulse_shaper.sv
`timescale 1ns/100ps
module pulse_shaper (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// control
	input  wire logic       fire,
	input  wire logic [4:0] width,
	// state
	output logic            busy
);
	import hs_pkg::*;

	typedef struct packed {
		logic [4:0] cnt;
		logic       busy;
	} shaper_type;

	shaper_type state;
	shaper_type next_state;

	always_comb begin
		next_state = state;
		if (state.busy) begin
			if (state.cnt == CNT_ONE) begin
				next_state.busy = 1'b0;
				next_state.cnt  = CNT_ZERO;
			end else begin
				next_state.cnt = state.cnt - CNT_ONE;
			end
		end else if (fire) begin
			next_state.busy = 1'b1;
			next_state.cnt  = width;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign busy = state.busy;
endmodule

// ===== src/debug_handshake_pulse_logic.sv
`timescale 1ns/100ps
// Overview of operation
// - handshake_on_cmd enables, handshake_off_cmd disables the completion pulse.
// - while enabled, pulse after each processor command completes.
// - handshake_on_cmd itself answers with a pulse after completing.
// - handshake starts disabled after every reset.
// - read pulse only after bus cycle done and read data ready.
// - write pulse only after all data received and bus cycle done.
// - unsupported targets ignore handshake_on_cmd and give no pulse.
// - halt_to_debug_cmd pulses once processor is in debug-halted state, at once if already halted.
// - resume_run_cmd pulses when processor leaves debug-halted state.
// - resume_until_halt_cmd resumes, pulses on next halt entry.
// - single_step_cmd runs one instruction, pulses on return to halt.
// - timing_measure_cmd cancels a pending run-control pulse.
module debug_handshake_pulse_logic (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	// decoded command from the serial shifter
	input  wire logic         cmd_valid,
	input  wire logic [2:0]   cmd_code,
	input  wire logic         single_step_cmd,
	input  wire logic         timing_measure_cmd,
	// completion sources
	input  wire logic         bus_cycle_done,
	input  wire logic         read_data_ready,
	input  wire logic         write_data_received,
	input  wire logic         cpu_halted,
	// debug_serial_pin
	input  wire logic         debug_serial_pin_in,
	input  wire logic         host_drives_line,
	output logic              debug_serial_pin_out,
	output logic              debug_serial_pin_oe,
	// status
	output logic              handshake_enabled,
	output logic              pulse_pending
);
	import hs_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic           enabled;
		wait_state_type wstate;
		logic           halted_d;
		logic           need_read;
		logic           need_write;
		logic           pin_oe;
		logic           pending;
	} ctl_type;

	ctl_type state;
	ctl_type next_state;
	logic    fire;
	logic    shaper_busy;
	logic    halt_rise;
	logic    halt_fall;

	function automatic logic bus_done_ok(input logic need_rd, input logic need_wr,
	                                     input logic done, input logic rd_ok,
	                                     input logic wr_ok);
		bus_done_ok = done && (!need_rd || rd_ok) && (!need_wr || wr_ok);
	endfunction

	assign halt_rise = cpu_halted && !state.halted_d;
	assign halt_fall = !cpu_halted && state.halted_d;

	// ****************************************
	// command tracking and pulse request
	// ****************************************
	always_comb begin
		next_state          = state;
		next_state.halted_d = cpu_halted;
		fire                = 1'b0;
		case (state.wstate)
			ST_IDLE: begin
				if (cmd_valid) begin
					case (cmd_code)
						CMD_HS_ON: begin
							next_state.enabled = 1'b1;
							next_state.wstate  = ST_WAIT_LINE;
						end
						CMD_HS_OFF: begin
							next_state.enabled = 1'b0;
						end
						CMD_READ: begin
							next_state.need_read  = 1'b1;
							next_state.need_write = 1'b0;
							next_state.wstate     = ST_WAIT_BUS;
						end
						CMD_WRITE: begin
							next_state.need_read  = 1'b0;
							next_state.need_write = 1'b1;
							next_state.wstate     = ST_WAIT_BUS;
						end
						CMD_HALT: next_state.wstate = ST_WAIT_HALT;
						CMD_RESUME: next_state.wstate = ST_WAIT_RUN;
						CMD_RESUME_UNTIL: next_state.wstate = ST_WAIT_STEP;
						// unsupported codes are ignored and never pulse
						default: next_state.wstate = ST_IDLE;
					endcase
				end else if (single_step_cmd) begin
					next_state.wstate = ST_WAIT_STEP;
				end
			end
			ST_WAIT_BUS: begin
				if (bus_done_ok(state.need_read, state.need_write, bus_cycle_done,
				                read_data_ready, write_data_received)) begin
					next_state.need_read  = 1'b0;
					next_state.need_write = 1'b0;
					next_state.wstate     = ST_WAIT_LINE;
				end
			end
			ST_WAIT_HALT: begin
				if (timing_measure_cmd) begin
					next_state.wstate = ST_IDLE;
				end else if (halt_rise || cpu_halted) begin
					next_state.wstate = ST_WAIT_LINE;
				end
			end
			ST_WAIT_RUN: begin
				if (timing_measure_cmd) begin
					next_state.wstate = ST_IDLE;
				end else if (halt_fall) begin
					next_state.wstate = ST_WAIT_LINE;
				end
			end
			ST_WAIT_STEP: begin
				// halt entry after running, from breakpoint or halt_instruction
				if (timing_measure_cmd) begin
					next_state.wstate = ST_IDLE;
				end else if (halt_rise) begin
					next_state.wstate = ST_WAIT_LINE;
				end
			end
			ST_WAIT_LINE: begin
				// without handshake the host times out on its own
				if (!state.enabled) begin
					next_state.wstate = ST_IDLE;
				end else if (!host_drives_line && !debug_serial_pin_in == 1'b0) begin
					fire              = 1'b1;
					next_state.pin_oe = 1'b1;
					next_state.wstate = ST_DRIVE;
				end
			end
			ST_DRIVE: begin
				if (!shaper_busy && !state.pin_oe) begin
					next_state.wstate = ST_IDLE;
				end else if (!shaper_busy && state.pin_oe) begin
					next_state.pin_oe = 1'b0;
					next_state.wstate = ST_IDLE;
				end
			end
			default: next_state.wstate = ST_IDLE;
		endcase
		next_state.pending = (next_state.wstate != ST_IDLE);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// pulse width timer
	// ****************************************
	pulse_shaper u_shaper (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.fire    (fire),
		.width   (PULSE_CYCLES),
		.busy    (shaper_busy)
	);

	assign debug_serial_pin_out = 1'b0;
	assign debug_serial_pin_oe  = state.pin_oe;
	assign handshake_enabled    = state.enabled;
	assign pulse_pending        = state.pending;
endmodule

// ===== tb/hs_checker.sv
`timescale 1ns/100ps
module hs_checker
	import hs_pkg::*;
(
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// command side
	input wire logic       cmd_valid,
	input wire logic [2:0] cmd_code,
	input wire logic       single_step_cmd,
	// pin side
	input wire logic       host_drives_line,
	input wire logic       debug_serial_pin_out,
	input wire logic       debug_serial_pin_oe,
	input wire logic       handshake_enabled,
	input wire logic       pulse_pending
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_reset_off: assert property ($rose(rst_n) |-> !handshake_enabled && !debug_serial_pin_oe)
		else $error("handshake or pulse active after reset");
	a_on_enables: assert property (cmd_valid && cmd_code == CMD_HS_ON && !pulse_pending
		|=> handshake_enabled && pulse_pending) else $error("enable command not taken");
	a_off_disables: assert property (cmd_valid && cmd_code == CMD_HS_OFF && !pulse_pending
		|=> !handshake_enabled) else $error("disable command not taken");
	a_oe_needs_en: assert property (debug_serial_pin_oe |-> handshake_enabled)
		else $error("pulse while disabled");
	a_line_free: assert property ($rose(debug_serial_pin_oe) |-> !$past(host_drives_line))
		else $error("pulse over a driven line");
	a_pin_low: assert property (debug_serial_pin_out == 1'h0)
		else $error("pin not driven low");
	a_pulse_held: assert property ($rose(debug_serial_pin_oe) |-> debug_serial_pin_oe[*8])
		else $error("pulse too short");
	a_pulse_ends: assert property ($rose(debug_serial_pin_oe) |-> ##[12:24] !debug_serial_pin_oe)
		else $error("pulse not released");
	a_wait_cause: assert property ($rose(pulse_pending) |-> $past(cmd_valid || single_step_cmd))
		else $error("wait without command");
endmodule
bind debug_handshake_pulse_logic hs_checker chk (.clk_sys, .rst_n, .cmd_valid, .cmd_code,
	.single_step_cmd, .host_drives_line, .debug_serial_pin_out, .debug_serial_pin_oe,
	.handshake_enabled, .pulse_pending);

// ===== tb/host_model.sv
`timescale 1ns/100ps
module host_model (
	// host control
	input  wire logic talk,
	// pin
	input  wire logic debug_serial_pin_oe,
	output logic      host_drives_line,
	output logic      debug_serial_pin_in,
	// seen pulses
	output int        pulses
);
	// host idles high while talking, pull-up holds it high otherwise
	assign host_drives_line = talk;
	assign debug_serial_pin_in = !debug_serial_pin_oe;
	initial pulses = 0;
	// counts only; never waits on it, so a silent target is tolerated
	always @(negedge debug_serial_pin_in) pulses++;
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb;
	import hs_pkg::*;
	logic clk_sys = 1'h0, rst_n = 1'h0, cmd_valid = 1'h0, single_step_cmd = 1'h0;
	logic timing_measure_cmd = 1'h0, bus_cycle_done = 1'h0, read_data_ready = 1'h0;
	logic write_data_received = 1'h0, cpu_halted = 1'h0, talk = 1'h0;
	logic [2:0] cmd_code = CMD_NONE;
	logic pin_in, line, pin_out, oe, en, pend;
	int pulses, base = 0, n_fail = 0, cmp_count = 0;
	always #10 clk_sys = ~clk_sys;
	debug_handshake_pulse_logic dut (.clk_sys, .rst_n, .cmd_valid, .cmd_code, .single_step_cmd,
		.timing_measure_cmd, .bus_cycle_done, .read_data_ready, .write_data_received,
		.cpu_halted, .debug_serial_pin_in(pin_in), .host_drives_line(line),
		.debug_serial_pin_out(pin_out), .debug_serial_pin_oe(oe), .handshake_enabled(en),
		.pulse_pending(pend));
	host_model host (.talk, .debug_serial_pin_oe(oe), .host_drives_line(line),
		.debug_serial_pin_in(pin_in), .pulses);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic cmd(input logic [2:0] c);
		@(posedge clk_sys);
		cmd_valid <= 1'h1;
		cmd_code <= c;
		@(posedge clk_sys);
		cmd_valid <= 1'h0;
	endtask
	task automatic quiet();
		cyc(20);
		chk(32'(pulses - base), 32'h0);
	endtask
	task automatic fin(input int exp);
		cyc(2);
		for (int i = 0; i < 60 && pend !== 1'h0; i++) @(posedge clk_sys);
		cyc(2);
		chk(32'(pulses - base), 32'(exp));
		base = pulses;
	endtask
	task automatic s_read();
		cmd(CMD_READ);
		bus_cycle_done <= 1'h1;
		quiet();
		read_data_ready <= 1'h1;
		fin(1);
	endtask
	task automatic s_write();
		cmd(CMD_WRITE);
		quiet();
		write_data_received <= 1'h1;
		fin(1);
	endtask
	task automatic s_run();
		cmd(CMD_HALT);
		quiet();
		cpu_halted <= 1'h1;
		fin(1);
		cmd(CMD_RESUME);
		quiet();
		cpu_halted <= 1'h0;
		fin(1);
		cmd(CMD_RESUME_UNTIL);
		quiet();
		cpu_halted <= 1'h1;
		fin(1);
		single_step_cmd <= 1'h1;
		cyc(1);
		single_step_cmd <= 1'h0;
		cpu_halted <= 1'h0;
		quiet();
		cpu_halted <= 1'h1;
		fin(1);
	endtask
	task automatic s_cancel();
		cmd(CMD_RESUME_UNTIL);
		cpu_halted <= 1'h0;
		timing_measure_cmd <= 1'h1;
		cyc(1);
		timing_measure_cmd <= 1'h0;
		cyc(3);
		chk(pend, 1'h0);
		cpu_halted <= 1'h1;
		quiet();
	endtask
	task automatic s_line();
		talk <= 1'h1;
		cmd(CMD_HALT);
		quiet();
		talk <= 1'h0;
		fin(1);
	endtask
	task automatic wrap_up();
		if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		cyc(4);
		rst_n <= 1'h1;
		cyc(2);
		chk(en, 1'h0);
		bus_cycle_done <= 1'h1;
		read_data_ready <= 1'h1;
		cmd(CMD_READ);
		fin(0);
		cmd(CMD_HS_ON);
		fin(1);
		chk(en, 1'h1);
		read_data_ready <= 1'h0;
		s_read();
		s_write();
		s_run();
		s_cancel();
		s_line();
		cmd(CMD_HS_OFF);
		fin(0);
		chk(en, 1'h0);
		cmd(CMD_WRITE);
		fin(0);
		cmd(CMD_HS_ON);
		fin(1);
		rst_n <= 1'h0;
		cyc(2);
		rst_n <= 1'h1;
		cyc(2);
		chk(en, 1'h0);
		wrap_up();
	end
	initial begin
		cyc(3000);
		n_fail++;
		wrap_up();
	end
endmodule
